/* design/pxbi_pkg.sv */
package pxbi_pkg;
   // bus command codes
   localparam logic [3:0] PXBI_CMD_INTA    = 4'h0;
   localparam logic [3:0] PXBI_CMD_SPECIAL = 4'h1;
   localparam logic [3:0] PXBI_CMD_IORD    = 4'h2;
   localparam logic [3:0] PXBI_CMD_IOWR    = 4'h3;
   localparam logic [3:0] PXBI_CMD_MRDW    = 4'h6;
   localparam logic [3:0] PXBI_CMD_MWR     = 4'h7;
   localparam logic [3:0] PXBI_CMD_ALRB    = 4'h8;
   localparam logic [3:0] PXBI_CMD_ALWB    = 4'h9;
   localparam logic [3:0] PXBI_CMD_CFGRD   = 4'hA;
   localparam logic [3:0] PXBI_CMD_CFGWR   = 4'hB;
   localparam logic [3:0] PXBI_CMD_SPLCPL  = 4'hC;
   localparam logic [3:0] PXBI_CMD_DAC     = 4'hD;
   localparam logic [3:0] PXBI_CMD_MRDB    = 4'hE;
   localparam logic [3:0] PXBI_CMD_MWRB    = 4'hF;
   // attribute and tag fields
   localparam int         PXBI_TD_NS_BIT   = 1;
   localparam logic [4:0] PXBI_TAG_VALUE   = 5'h00;
   // split completion message indices
   localparam logic [7:0] PXBI_MSG_MABORT  = 8'h00;
   localparam logic [7:0] PXBI_MSG_TABORT  = 8'h01;
   // sizes
   localparam logic [12:0] PXBI_PAGE_BYTES = 13'h1000;
   localparam logic [10:0] PXBI_ADQ_BYTES  = 11'h080;
   localparam logic [2:0]  PXBI_SRQ_CUR    = 3'h4;
   localparam logic [2:0]  PXBI_SRQ_PEND   = 3'h4;
   localparam int          PXBI_NCPL       = 4;
   localparam int          PXBI_FIFO_DEPTH = 4;
   localparam int          PXBI_FIFO_WIDTH = 38;
   // claim delay in clocks after the address phase(s)
   localparam int          PXBI_CLAIM_CLKS = 2;
   localparam logic [7:0]  PXBI_MLT_RST    = 8'h00;
endpackage

/* design/pxbi_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module pxbi_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              do_push = in_valid && in_ready;
   wire              do_pop  = out_valid && out_ready;
   // honest flags straight from the occupancy count
   assign in_ready  = (count < (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   // storage; no reset needed on the data array
   always_ff @(posedge clk) begin
      if (do_push) mem[wr_ptr] <= in_data;
   end
   // pointers and count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (do_pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule // pxbi_fifo
`default_nettype wire

/* design/pxbi_top.sv */
// Contract
// - Master issues only I/O, mem dword read/write, config, split cpl, DAC, read block.
// - Target accepts memory, alias, split cpl, DAC, block cmds; never I/O, config, others.
// - Target no-snoop goes upstream in descriptor attr bit 1; never set when mastering.
// - Relaxed ordering never applied nor set on requests from upstream.
// - At most one own request outstanding; requester tag always 0.
// - Master byte count derives from upstream dword length field.
// - Master bursts end at the next 4 KB boundary.
// - Target bursts may continue past a 4 KB boundary.
// - Target burst reads never get immediate data; they are split unless retried.
// - Master burst read only with 128 bytes return space free.
// - Claim output asserts exactly 2 clocks after the address phase.
// - Target never inserts wait states; it ends the transfer instead.
// - Byte-count-modified bit always cleared in sent split completions.
// - Completion error only for upstream-aborted reads; message bit equals it.
// - Completion message bit always equals completion error bit.
// - Own split completion claimed, data discarded on tag mismatch or a byte count above the request.
// - Only one completion-requiring request pending per bus at a time.
// - Aborts give bridge-error messages index 00h master, 01h target.
// - Fair completion arbitration; latency expiry ends current, reloads, starts next.
// - Completion out of data with others active switches early.
// - Retry when split queue holds 4 current and 4 pending; keep no state.
`timescale 1ns/1ps
`default_nettype none
module pxbi_top
   import pxbi_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // target side of the bus
   input  wire logic                tgt_addr_valid,
   input  wire logic [3:0]          tgt_cmd,
   input  wire logic [31:0]         tgt_addr,
   input  wire logic                tgt_attr_ns,
   input  wire logic                tgt_attr_ro,
   input  wire logic                tgt_rid_match,
   input  wire logic [4:0]          tgt_cpl_tag,
   input  wire logic [12:0]         tgt_cpl_bytes,
   input  wire logic                tgt_data_valid,
   input  wire logic [31:0]         tgt_data,
   input  wire logic                tgt_xfer_end,
   input  wire logic [2:0]          srq_cur_cnt,
   input  wire logic [2:0]          srq_pend_cnt,
   output logic                     bus_claim_n,
   output logic                     tgt_split_resp,
   output logic                     tgt_retry,
   output logic                     tgt_disconnect,
   output logic                     tgt_cpl_discard,
   // upstream packet stream toward the memory controller hub
   output logic                     up_valid,
   input  wire logic                up_ready,
   output logic [PXBI_FIFO_WIDTH-1:0] up_packet,
   // requests from upstream to master on the bus
   input  wire logic                hub_req_valid,
   input  wire logic [3:0]          hub_req_cmd,
   input  wire logic [31:0]         hub_req_addr,
   input  wire logic [9:0]          hub_req_len,
   output logic                     hub_req_ready,
   input  wire logic [10:0]         ret_space_bytes,
   input  wire logic                m_done,
   output logic                     m_start,
   output logic [3:0]               m_cmd,
   output logic [31:0]              m_addr,
   output logic [12:0]              m_byte_count,
   output logic [4:0]               m_tag,
   output logic                     m_attr_ns,
   output logic                     m_attr_ro,
   output logic                     m_busy,
   output logic                     m_cpl_pending,
   // split completions toward the bus
   input  wire logic [PXBI_NCPL-1:0] cpl_active,
   input  wire logic [PXBI_NCPL-1:0] cpl_data_avail,
   input  wire logic [PXBI_NCPL-1:0] cpl_mabort,
   input  wire logic [PXBI_NCPL-1:0] cpl_tabort,
   input  wire logic                sc_bus_owned,
   input  wire logic [7:0]          cfg_mlt,
   output logic                     sc_run,
   output logic                     sc_end,
   output logic [1:0]               sc_sel,
   output logic                     sc_sce,
   output logic                     sc_scm,
   output logic                     sc_bcm,
   output logic [7:0]               sc_msg_index,
   output logic [7:0]               sc_mlt_count
);
   // ---------------- target decode ----------------
   typedef enum logic [3:0] {
      PXBI_T_IDLE  = 4'b0001,
      PXBI_T_DEC   = 4'b0010,
      PXBI_T_CLAIM = 4'b0100,
      PXBI_T_DONE  = 4'b1000
   } pxbi_tstate_t;
   pxbi_tstate_t tstate;
   pxbi_tstate_t next_tstate;

   wire is_mem_rd   = (tgt_cmd == PXBI_CMD_MRDW) || (tgt_cmd == PXBI_CMD_MRDB) ||
                      (tgt_cmd == PXBI_CMD_ALRB);
   wire is_mem_wr   = (tgt_cmd == PXBI_CMD_MWR) || (tgt_cmd == PXBI_CMD_MWRB) ||
                      (tgt_cmd == PXBI_CMD_ALWB);
   wire is_spl_cpl  = (tgt_cmd == PXBI_CMD_SPLCPL) && tgt_rid_match;
   // DAC is claimed; the decode of its second phase is left to the address pipe
   wire tgt_accept  = is_mem_rd || is_mem_wr || is_spl_cpl ||
                      (tgt_cmd == PXBI_CMD_DAC);
   wire srq_full    = (srq_cur_cnt == PXBI_SRQ_CUR) && (srq_pend_cnt == PXBI_SRQ_PEND);
   wire fifo_ready;
   // completions use their own buffer, so only requests see the queue limit
   wire need_retry  = !is_spl_cpl && (srq_full || !fifo_ready);
   logic [12:0] orig_bytes;
   // a completion we own is bad on a stray tag or when it outgrows the request
   wire cpl_bad     = (tgt_cpl_tag != PXBI_TAG_VALUE) || !m_cpl_pending ||
                      (tgt_cpl_bytes > orig_bytes);
   logic        cur_rd;
   logic        cur_wr;
   logic        cur_cpl;
   logic        cur_retry;
   logic        cur_ns;
   logic [31:0] cur_addr;
   wire  start_claim = tgt_addr_valid && tgt_accept;

   // next state of the target claim sequence
   always_comb begin
      next_tstate = tstate;
      case (tstate)
         PXBI_T_IDLE:  if (start_claim) next_tstate = PXBI_T_DEC;
         PXBI_T_DEC:   next_tstate = PXBI_T_CLAIM;
         PXBI_T_CLAIM: if (tgt_xfer_end || tgt_disconnect) next_tstate = PXBI_T_DONE;
         PXBI_T_DONE:  next_tstate = PXBI_T_IDLE;
         default:      next_tstate = PXBI_T_IDLE;
      endcase
   end

   // target sequence registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tstate    <= PXBI_T_IDLE;
         cur_rd    <= 1'b0;
         cur_wr    <= 1'b0;
         cur_cpl   <= 1'b0;
         cur_retry <= 1'b0;
         cur_ns    <= 1'b0;
         cur_addr  <= 32'h0000_0000;
      end else begin
         tstate <= next_tstate;
         if (tstate == PXBI_T_IDLE && start_claim) begin
            cur_rd    <= is_mem_rd;
            cur_wr    <= is_mem_wr;
            cur_cpl   <= is_spl_cpl;
            cur_retry <= need_retry;
            cur_ns    <= tgt_attr_ns;
            cur_addr  <= tgt_addr;
         end
      end
   end

   // claim goes out on the second edge after the address phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) bus_claim_n <= 1'b1;
      else         bus_claim_n <= !(next_tstate == PXBI_T_CLAIM);
   end

   wire in_claim_first = (tstate == PXBI_T_DEC);
   // termination answers, one pulse with the claim
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tgt_split_resp  <= 1'b0;
         tgt_retry       <= 1'b0;
         tgt_cpl_discard <= 1'b0;
      end else begin
         // reads never get immediate data; all that are not retried go split
         tgt_split_resp  <= in_claim_first && cur_rd && !cur_retry;
         tgt_retry       <= in_claim_first && cur_retry;
         tgt_cpl_discard <= in_claim_first && cur_cpl && cpl_bad;
      end
   end

   // no wait states: a data phase the buffer cannot take ends the transfer
   assign tgt_disconnect = (tstate == PXBI_T_CLAIM) && cur_wr && tgt_data_valid &&
                           !fifo_ready;

   // packets upstream: descriptor on claim, then write data; no 4 KB check here
   wire        push_desc = in_claim_first && (cur_rd || cur_wr) && !cur_retry;
   wire        push_data = (tstate == PXBI_T_CLAIM) && cur_wr && tgt_data_valid;
   wire [1:0]  td_attr   = {cur_ns, 1'b0};
   wire [PXBI_FIFO_WIDTH-1:0] fifo_in =
      push_desc ? {1'b1, 1'b0, cur_rd, td_attr, 1'b0, cur_addr} :
                  {1'b0, 5'h00, tgt_data};

   pxbi_fifo #(
      .WIDTH (PXBI_FIFO_WIDTH),
      .DEPTH (PXBI_FIFO_DEPTH)
   ) u_upq (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (push_desc || push_data),
      .in_ready  (fifo_ready),
      .in_data   (fifo_in),
      .out_valid (up_valid),
      .out_ready (up_ready),
      .out_data  (up_packet)
   );

   // ---------------- master side ----------------
   wire master_ok  = (hub_req_cmd == PXBI_CMD_IORD) || (hub_req_cmd == PXBI_CMD_IOWR) ||
                     (hub_req_cmd == PXBI_CMD_MRDW) || (hub_req_cmd == PXBI_CMD_MWR) ||
                     (hub_req_cmd == PXBI_CMD_CFGRD) || (hub_req_cmd == PXBI_CMD_CFGWR) ||
                     (hub_req_cmd == PXBI_CMD_SPLCPL) || (hub_req_cmd == PXBI_CMD_DAC) ||
                     (hub_req_cmd == PXBI_CMD_MRDB);
   wire is_burst_rd = (hub_req_cmd == PXBI_CMD_MRDB);
   wire needs_cpl   = (hub_req_cmd != PXBI_CMD_MWR) && (hub_req_cmd != PXBI_CMD_SPLCPL) &&
                      (hub_req_cmd != PXBI_CMD_DAC);
   wire space_ok    = !is_burst_rd || (ret_space_bytes >= PXBI_ADQ_BYTES);
   // a fresh request waits for the previous one and for its completion
   wire slot_free   = !m_busy && !m_cpl_pending;
   // unsupported codes are drained without issuing anything
   assign hub_req_ready = slot_free && (space_ok || !master_ok);
   wire issue       = hub_req_valid && hub_req_ready && master_ok;

   wire [12:0] len_bytes  = {1'b0, hub_req_len, 2'b00};
   wire [12:0] to_page    = PXBI_PAGE_BYTES - {1'b0, hub_req_addr[11:0]};
   wire [12:0] len_full   = (hub_req_len == 10'h000) ? PXBI_PAGE_BYTES : len_bytes;
   wire [12:0] next_bytes = (len_full > to_page) ? to_page : len_full;

   // master request registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         m_start       <= 1'b0;
         m_cmd         <= PXBI_CMD_INTA;
         m_addr        <= 32'h0000_0000;
         m_byte_count  <= 13'h0000;
         m_busy        <= 1'b0;
         m_cpl_pending <= 1'b0;
         orig_bytes    <= 13'h0000;
      end else begin
         m_start <= issue;
         if (issue) begin
            m_cmd        <= hub_req_cmd;
            m_addr       <= hub_req_addr;
            m_byte_count <= next_bytes;
            orig_bytes   <= next_bytes;
            m_busy       <= 1'b1;
         end else if (m_done) begin
            m_busy <= 1'b0;
         end
         // the good completion clears the pending mark; an issue that needs a completion sets it
         if (issue && needs_cpl)
            m_cpl_pending <= 1'b1;
         else if (in_claim_first && cur_cpl && !cpl_bad)
            m_cpl_pending <= 1'b0;
      end
   end
   assign m_tag     = PXBI_TAG_VALUE;
   assign m_attr_ns = 1'b0;
   assign m_attr_ro = 1'b0;

   // ---------------- split completion arbitration ----------------
   // round robin search after the current pointer
   function automatic logic [1:0] pxbi_next_cpl(input logic [PXBI_NCPL-1:0] act,
                                               input logic [1:0] cur);
      logic [1:0] pick;
      logic [1:0] idx;
      pick = cur;
      for (int i = PXBI_NCPL - 1; i >= 1; i--) begin
         idx = 2'(cur + 2'(i));
         if (act[idx]) pick = idx;
      end
      return pick;
   endfunction

   wire [1:0] rr_next     = pxbi_next_cpl(cpl_active, sc_sel);
   wire       others_act  = |(cpl_active & ~(4'h1 << sc_sel));
   wire       mlt_expired = sc_run && sc_bus_owned && (sc_mlt_count == 8'h00);
   wire       out_of_data = sc_run && !cpl_data_avail[sc_sel] && others_act;
   wire       cur_gone    = sc_run && !cpl_active[sc_sel];
   // expiry ends the run even with nobody else asking for the bus
   assign sc_end         = mlt_expired || out_of_data || cur_gone;
   wire       sc_begin    = !sc_run && (|cpl_active);

   // arbiter and latency timer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sc_run       <= 1'b0;
         sc_sel       <= 2'b00;
         sc_mlt_count <= PXBI_MLT_RST;
      end else if (sc_end) begin
         sc_run       <= 1'b0;
         sc_sel       <= rr_next;
      end else if (sc_begin) begin
         sc_run       <= 1'b1;
         sc_sel       <= cpl_active[sc_sel] ? sc_sel : rr_next;
         sc_mlt_count <= cfg_mlt;
      end else if (sc_run && sc_bus_owned && sc_mlt_count != 8'h00) begin
         sc_mlt_count <= sc_mlt_count - 8'h01;
      end
   end

   // completer attribute fields of the running completion
   wire abort_any  = cpl_mabort[sc_sel] || cpl_tabort[sc_sel];
   assign sc_sce       = sc_run && abort_any;
   assign sc_scm       = sc_sce;
   assign sc_bcm       = 1'b0;
   assign sc_msg_index = cpl_mabort[sc_sel] ? PXBI_MSG_MABORT : PXBI_MSG_TABORT;

   // ---------------- checks ----------------
   // claim lands on the second edge, never sooner
   a_claim_timing: assert property (@(posedge clk) disable iff (sys_rst)
      (tstate == PXBI_T_IDLE && start_claim) |-> bus_claim_n ##1 bus_claim_n ##1 !bus_claim_n)
      else $error("claim not two clocks after address phase");

   // unsupported codes stay unclaimed
   a_no_claim_bad: assert property (@(posedge clk) disable iff (sys_rst)
      (tstate == PXBI_T_IDLE && tgt_addr_valid && (tgt_cmd == PXBI_CMD_IORD ||
       tgt_cmd == PXBI_CMD_CFGRD || tgt_cmd == PXBI_CMD_INTA)) |-> ##2 bus_claim_n)
      else $error("unsupported command claimed");

   // own requests carry tag 0 and clear attributes
   a_master_tag: assert property (@(posedge clk) disable iff (sys_rst)
      m_start |-> (m_tag == 5'h00) && !m_attr_ro && !m_attr_ns && $past(slot_free))
      else $error("bad master tag or attributes");

   // a burst never runs past the page end
   a_page_limit: assert property (@(posedge clk) disable iff (sys_rst)
      m_start |-> ({1'b0, m_addr[11:0]} + m_byte_count) <= PXBI_PAGE_BYTES)
      else $error("master burst crosses 4 KB");

   // burst reads wait for return space
   a_adq_space: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && is_burst_rd) |-> ret_space_bytes >= 11'h080)
      else $error("burst read without return space");

   // reads that are not retried are always answered split
   a_split_read: assert property (@(posedge clk) disable iff (sys_rst)
      (tstate == PXBI_T_IDLE && start_claim && is_mem_rd && !need_retry)
      |-> ##2 tgt_split_resp)
      else $error("read not split");

   // a full split queue forces a retry
   a_retry_full: assert property (@(posedge clk) disable iff (sys_rst)
      (tstate == PXBI_T_IDLE && start_claim && !is_spl_cpl && srq_full)
      |-> ##2 tgt_retry && !tgt_split_resp)
      else $error("full queue not retried");

   // completer attributes follow the abort flags
   a_scm_shadow: assert property (@(posedge clk) disable iff (sys_rst)
      (sc_scm == sc_sce) && !sc_bcm && (sc_sce == (sc_run && abort_any)))
      else $error("completion attributes wrong");

   // expiry hands the bus to the next completion
   sequence pxbi_run_expire;
      sc_run && sc_bus_owned && sc_mlt_count == 8'h00;
   endsequence
   a_mlt_switch: assert property (@(posedge clk) disable iff (sys_rst)
      pxbi_run_expire |-> sc_end ##1 (!sc_run && sc_sel == $past(rr_next)))
      else $error("latency expiry did not switch");

   // timer counts down while the bus is ours
   a_mlt_count: assert property (@(posedge clk) disable iff (sys_rst)
      (sc_run && sc_bus_owned && !sc_end && sc_mlt_count != 8'h00)
      |=> sc_mlt_count == $past(sc_mlt_count) - 8'h01)
      else $error("latency timer not counting");

   // a dry completion yields to another active one
   a_no_data: assert property (@(posedge clk) disable iff (sys_rst)
      (sc_run && !cpl_data_avail[sc_sel] && others_act) |=> !sc_run && sc_sel != $past(sc_sel))
      else $error("empty completion kept the bus");

   // stray completions are claimed and dropped
   a_cpl_discard: assert property (@(posedge clk) disable iff (sys_rst)
      (tstate == PXBI_T_IDLE && start_claim && is_spl_cpl && tgt_cpl_tag != 5'h00)
      |-> ##2 (tgt_cpl_discard && !bus_claim_n))
      else $error("stray completion not discarded");

   // a refused data phase releases the claim at once
   a_disc_release: assert property (@(posedge clk) disable iff (sys_rst)
      tgt_disconnect |=> bus_claim_n)
      else $error("claim held after disconnect");
endmodule // pxbi_top
`default_nettype wire

/* bench/pxbi_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side target of own requests: finishes each one after a chosen delay
module pxbi_far_model (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       m_start,
   input  wire logic [3:0] slow,
   output logic            m_done
);
   logic [3:0] cnt;
   logic       run;
   // one counter is enough, only one own request is ever outstanding
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {run, cnt, m_done} <= 6'h00;
      end else begin
         m_done <= run && cnt == 4'h0;
         run    <= m_start || (run && cnt != 4'h0);
         cnt    <= m_start ? slow : cnt - 4'h1;
      end
   end
endmodule // pxbi_far_model
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pxbi_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, tgt_addr_valid = 1'b0, tgt_attr_ns = 1'b0;
   logic tgt_attr_ro = 1'b0, tgt_rid_match = 1'b1, tgt_xfer_end = 1'b0, up_ready = 1'b1;
   logic hub_req_valid = 1'b0, sc_bus_owned = 1'b0, qfull = 1'b0, qdat = 1'b0;
   logic tgt_data_valid = 1'b0;
   logic [3:0]  tgt_cmd = 4'h0, hub_req_cmd = 4'h0, slow = 4'h1, c;
   logic [31:0] tgt_addr = 32'h0, hub_req_addr = 32'h0, ra;
   logic [4:0]  tgt_cpl_tag = 5'h00;
   logic [12:0] tgt_cpl_bytes = 13'h0000;
   logic [2:0]  srq_cur_cnt = 3'h0, srq_pend_cnt = 3'h0;
   logic [9:0]  hub_req_len = 10'h000, rl;
   logic [10:0] ret_space_bytes = 11'h7FF;
   logic [3:0]  cpl_active = 4'h0, cpl_data_avail = 4'h0, cpl_mabort = 4'h0, cpl_tabort = 4'h0;
   logic [7:0]  cfg_mlt = 8'h03, sc_msg_index, sc_mlt_count;
   logic bus_claim_n, tgt_split_resp, tgt_retry, tgt_disconnect, tgt_cpl_discard, up_valid;
   logic hub_req_ready, m_done, m_start, m_busy, m_cpl_pending, m_attr_ns, m_attr_ro;
   logic sc_run, sc_end, sc_sce, sc_scm, sc_bcm;
   logic [PXBI_FIFO_WIDTH-1:0] up_packet;
   logic [31:0] m_addr;
   logic [12:0] m_byte_count;
   logic [4:0]  m_tag;
   logic [3:0]  m_cmd;
   logic [1:0]  sc_sel, s;
   int fail_count = 0, n_checks = 0, cyc = 0, seed = 42, i, k;
   pxbi_top pxbi_top_i (.clk, .sys_rst, .tgt_addr_valid, .tgt_cmd, .tgt_addr, .tgt_attr_ns,
      .tgt_attr_ro, .tgt_rid_match, .tgt_cpl_tag, .tgt_cpl_bytes, .tgt_data_valid,
      .tgt_data(tgt_addr), .tgt_xfer_end, .srq_cur_cnt, .srq_pend_cnt, .bus_claim_n, .tgt_split_resp,
      .tgt_retry, .tgt_disconnect, .tgt_cpl_discard, .up_valid, .up_ready, .up_packet,
      .hub_req_valid, .hub_req_cmd, .hub_req_addr, .hub_req_len, .hub_req_ready, .ret_space_bytes,
      .m_done, .m_start, .m_cmd, .m_addr, .m_byte_count, .m_tag, .m_attr_ns, .m_attr_ro, .m_busy,
      .m_cpl_pending, .cpl_active, .cpl_data_avail, .cpl_mabort, .cpl_tabort, .sc_bus_owned,
      .cfg_mlt, .sc_run, .sc_end, .sc_sel, .sc_sce, .sc_scm, .sc_bcm, .sc_msg_index, .sc_mlt_count);
   pxbi_far_model pxbi_far_model_i (.clk, .sys_rst, .m_start, .slow, .m_done);
   // clock and hang guard
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // bounded wait, leaves k holding the cycles spent
   task automatic wait_on(ref logic sig, input logic v);
      for (k = 0; k < 30 && sig !== v; k++) begin
         @(posedge clk);
         #1;
      end
      chk(sig, v);
   endtask
   function automatic logic needs_cpl(input logic [3:0] cm);
      return cm inside {4'h2, 4'h3, 4'h6, 4'hA, 4'hB, 4'hE};
   endfunction
   // byte count clipped at the next page boundary
   function automatic logic [12:0] exp_bc(input logic [9:0] l, input logic [31:0] a);
      logic [12:0] n;
      n = (l == 10'h000) ? 13'h1000 : {1'b0, l, 2'b00};
      return (n < 13'h1000 - a[11:0]) ? n : 13'h1000 - a[11:0];
   endfunction
   // one target transaction: address phase, claim, end pulse
   task automatic tgt_tx(input logic [3:0] cm, input logic f, input logic dis, input logic [17:0] cb);
      logic [31:0] a;
      logic ok, rd, rty;
      a = $random(seed);
      ok = cm inside {4'h6, 4'h7, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF};
      rd = cm inside {4'h6, 4'h8, 4'hE};
      rty = ok && cm != 4'hC && (f || qfull);
      @(posedge clk);
      {tgt_cmd, tgt_addr, tgt_addr_valid, tgt_attr_ns, tgt_attr_ro} <= {cm, a, 1'b1, a[7:6]};
      {tgt_cpl_tag, tgt_cpl_bytes} <= cb;
      srq_cur_cnt <= f ? 3'h4 : 3'(a[9:8]);
      srq_pend_cnt <= 3'h4;
      @(posedge clk);
      tgt_addr_valid <= 1'b0;
      #1 chk(bus_claim_n, 1'b1);
      @(posedge clk);
      tgt_data_valid <= qdat;
      #1 chk({bus_claim_n, tgt_retry}, {!ok, rty});
      chk(tgt_disconnect, qdat);
      if (rd) chk(tgt_split_resp, !rty);
      if (cm == 4'hC) chk(tgt_cpl_discard, dis);
      if (ok && !rty && up_ready && !(cm inside {4'hC, 4'hD})) begin
         chk({up_valid, up_packet[35:33], up_packet[31:0]}, {1'b1, rd, a[7], 1'b0, a});
      end
      @(posedge clk);
      {tgt_xfer_end, tgt_data_valid} <= 2'b10;
      @(posedge clk);
      tgt_xfer_end <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(bus_claim_n, 1'b1);
   endtask
   // one request from upstream, handed over when ready is sampled high
   task automatic mst(input logic [3:0] cm, input logic [31:0] a, input logic [9:0] l);
      logic ok;
      ok = needs_cpl(cm) || cm inside {4'h7, 4'hC, 4'hD};
      @(posedge clk);
      {hub_req_cmd, hub_req_addr, hub_req_len, hub_req_valid} <= {cm, a, l, 1'b1};
      slow <= 4'(a[14:12]);
      #1 wait_on(hub_req_ready, 1'b1);
      @(posedge clk);
      hub_req_valid <= 1'b0;
      #1 chk(m_start, ok);
      if (ok) chk({m_cmd, m_addr, m_byte_count, m_tag, m_attr_ns, m_attr_ro},
         {cm, a, exp_bc(l, a), PXBI_TAG_VALUE, 2'b00});
      wait_on(m_busy, 1'b0);
      chk({m_cpl_pending, hub_req_ready}, {needs_cpl(cm), !needs_cpl(cm)});
   endtask
   initial begin
      repeat (6) @(posedge clk);
      chk({bus_claim_n, hub_req_ready, sc_run, up_valid, m_busy}, 5'b11000);
      sys_rst <= 1'b0;
      for (i = 0; i < 16; i++) tgt_tx(4'(i), i == 6 || i == 9, 1'b1, 18'h0);
      // burst read withheld below one aligned data quantum of space
      @(posedge clk);
      {ret_space_bytes, hub_req_cmd, hub_req_valid} <= {11'h07F, PXBI_CMD_MRDB, 1'b1};
      repeat (4) @(posedge clk);
      #1 chk({hub_req_ready, m_start}, 2'b00);
      @(posedge clk);
      {ret_space_bytes, hub_req_valid} <= {PXBI_ADQ_BYTES, 1'b0};
      mst(PXBI_CMD_MRDB, 32'h0000_0FF0, 10'h010);
      tgt_tx(PXBI_CMD_SPLCPL, 1'b0, 1'b1, {5'h01, 13'h0010});
      tgt_tx(PXBI_CMD_SPLCPL, 1'b0, 1'b1, {5'h00, 13'h0011});
      tgt_tx(PXBI_CMD_SPLCPL, 1'b0, 1'b0, {5'h00, 13'h0010});
      chk(m_cpl_pending, 1'b0);
      // every code once, then random ones; reads get a good completion back
      for (i = 0; i < 40; i++) begin
         c = (i < 16) ? 4'(i) : 4'($random(seed));
         ra = $random(seed);
         rl = 10'($random(seed));
         mst(c, ra, rl);
         if (needs_cpl(c)) tgt_tx(PXBI_CMD_SPLCPL, 1'b0, 1'b0, {5'h00, exp_bc(rl, ra)});
      end
      // stalled upstream: four descriptors fill the buffer, the fifth is refused
      @(posedge clk);
      up_ready <= 1'b0;
      for (i = 0; i < 5; i++) begin
         qfull = (i == 4);
         qdat = (i == 3);
         tgt_tx(PXBI_CMD_MWR, 1'b0, 1'b1, 18'h0);
      end
      {qfull, qdat} = 2'b00;
      @(posedge clk);
      up_ready <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(up_valid, 1'b1);
      @(posedge clk);
      #1 chk(up_valid, 1'b0);
      // arbitration: 0 master abort, 1 clean, 2 target abort
      @(posedge clk);
      {cpl_active, cpl_data_avail, cpl_mabort, cpl_tabort} <= 16'h7714;
      sc_bus_owned <= 1'b1;
      #1;
      for (i = 0; i < 6; i++) begin
         wait_on(sc_run, 1'b1);
         s = sc_sel;
         wait_on(sc_end, 1'b1);
         chk(k, cfg_mlt);
         chk({sc_sce, sc_scm, sc_bcm}, {s != 2'h1, s != 2'h1, 1'b0});
         if (s != 2'h1) chk(sc_msg_index, s == 2'h0 ? PXBI_MSG_MABORT : PXBI_MSG_TABORT);
         @(posedge clk);
         #1 chk(sc_sel, s == 2'h2 ? 2'h0 : s + 2'h1);
      end
      wait_on(sc_run, 1'b1);
      @(posedge clk);
      cpl_data_avail <= 4'h7 & ~(4'h1 << sc_sel);
      #1 chk(sc_end, 1'b1);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
